//--- dv/bfs_breaker_model.sv
`timescale 1ns/1ns
`default_nettype none
module bfs_breaker_model #(
  parameter int OPEN_CYC = 5
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        trip_cmd,
  input  wire logic        retrip,
  input  wire logic        stuck,
  input  wire logic [15:0] load,
  output logic      [15:0] cur
);
  int   cnt;
  logic opened;

  // ********
  // Breaker: either coil opens it, a stuck one carries load regardless
  // ********
  always_ff @(posedge clk) begin
    if (rst || !(trip_cmd || retrip)) begin
      cnt    <= 0;
      opened <= 1'b0;
    end else if (!stuck && cnt < OPEN_CYC) begin
      cnt <= cnt + 1;
    end else if (!stuck) begin
      opened <= 1'b1;
    end
  end

  assign cur = opened ? 16'h0000 : load;
endmodule : bfs_breaker_model
`default_nettype wire

//--- dv/bfs_check_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module bfs_check_asserts #(
  parameter int TICK_CYC = 10
) (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        start_out,
  input wire logic        retrip_out,
  input wire logic        failure_out,
  input wire logic        blocked_out,
  input wire logic        irq,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata
);
  wire  [3:0] outs = {start_out, retrip_out, failure_out, blocked_out};
  logic [3:0] outs_q;
  logic       seen;
  int         gap;

  // ********
  // Spacing of output changes, judged only after a first change
  // ********
  always_ff @(posedge clk) begin
    outs_q <= outs;
    seen   <= !rst && (seen || outs != outs_q);
    gap    <= (rst || outs != outs_q) ? 1 : gap + 1;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  out_tick_grid_a: assert property (
    seen && outs != outs_q |-> gap % TICK_CYC == 0) else $error("output moved off tick");
  blocked_stops_a: assert property (
    blocked_out |-> !retrip_out && !failure_out) else $error("blocked yet timing");
  reset_clear_a: assert property (
    $fell(rst) |-> !outs && !irq && !s_axi_bvalid && !s_axi_rvalid) else $error("dirty reset");
  write_answer_a: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("late write response");
  read_answer_a: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("late read data");
  bresp_hold_a: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
  rdata_hold_a: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata moved");
  write_busy_a: assert property (
    s_axi_bvalid |-> !s_axi_awready) else $error("awready while busy");
  read_busy_a: assert property (
    s_axi_rvalid |-> !s_axi_arready) else $error("arready while busy");
endmodule : bfs_check_asserts

bind breaker_failure_supervisor bfs_check_asserts #(.TICK_CYC(TICK_CYC)) chk (
  .clk, .rst, .start_out, .retrip_out, .failure_out, .blocked_out, .irq,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
  .s_axi_rdata);
`default_nettype wire

//--- dv/test_breaker_failure_supervisor.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, a) begin n_compared++; if ((a) !== (e)) begin num_errors++; \
  $display("[ERR] %s exp %0h got %0h", n, e, a); end end
module test_breaker_failure_supervisor;
  localparam int TCYC = 10;
  // Retrip must lie beyond the open time plus two ticks of pick-up lag
  localparam int RT   = 3;
  localparam int FT   = 6;
  int          seed = 32'h70ED;
  int          num_errors = 0, n_compared = 0, waited, cyc = 0, t_st = 0, t_rt = 0, t_fl = 0, k;
  logic        clk = 1'b0, rst = 1'b1, trip_cmd = 1'b0, stuck = 1'b0, block_in = 1'b0;
  logic        setting_group_change = 1'b0, start_out, retrip_out, failure_out, blocked_out, irq;
  logic [2:0]  prev = 3'h0;
  logic [15:0] load = 16'h0000, phase_one_fundamental, phase_two_fundamental = 16'h0000;
  logic [15:0] phase_three_fundamental = 16'h0000, residual_input_one = 16'h0000;
  logic [15:0] residual_input_two = 16'h0000, calculated_residual = 16'h0000;
  logic [7:0]  trip_events = 8'h00, relay_commands = 8'h00, ev;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [7:0]  reg_addr [6] = '{bfs_pkg::ADDR_CTRL, bfs_pkg::ADDR_PHASE_THR,
    bfs_pkg::ADDR_RES_THR, bfs_pkg::ADDR_RETRIP_T, bfs_pkg::ADDR_FAIL_T, bfs_pkg::ADDR_STATUS};
  logic [31:0] reg_rst [6] = '{bfs_pkg::CTRL_RESET, bfs_pkg::PHASE_THR_RESET,
    bfs_pkg::RES_THR_RESET, bfs_pkg::RETRIP_T_RESET, bfs_pkg::FAIL_T_RESET, 32'h0};

  breaker_failure_supervisor #(.TICK_CYC(TCYC)) uut (
    .clk, .rst, .phase_one_fundamental, .phase_two_fundamental, .phase_three_fundamental,
    .residual_input_one, .residual_input_two, .calculated_residual, .trip_events,
    .relay_commands, .block_in, .setting_group_change, .start_out, .retrip_out, .failure_out,
    .blocked_out, .irq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);
  bfs_breaker_model #(.OPEN_CYC(5)) brk (
    .clk, .rst, .trip_cmd, .retrip(retrip_out), .stuck, .load, .cur(phase_one_fundamental));

  always #10 clk = ~clk;

  // ********
  // Background noise below every threshold, and edge timestamps
  // ********
  always @(posedge clk) begin
    phase_two_fundamental   <= 16'($random(seed)) & 16'h007F;
    phase_three_fundamental <= 16'($random(seed)) & 16'h007F;
    residual_input_one      <= 16'($random(seed)) & 16'h003F;
    residual_input_two      <= 16'($random(seed)) & 16'h003F;
    calculated_residual     <= 16'($random(seed)) & 16'h003F;
    setting_group_change    <= 1'($random(seed));
    cyc  <= cyc + 1;
    prev <= {start_out, retrip_out, failure_out};
    if (start_out && !prev[2]) t_st <= cyc;
    if (retrip_out && !prev[1]) t_rt <= cyc;
    if (failure_out && !prev[0]) t_fl <= cyc;
  end

  function automatic int exp_ticks(input int n);
    return n * TCYC;
  endfunction : exp_ticks

  task automatic give_verdict;
    if (num_errors == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : give_verdict

  task automatic wait_for(ref logic s, input logic v);
    waited = 0;
    while (s !== v && waited < 80) begin
      @(posedge clk);
      waited++;
    end
    if (s !== v) begin
      `CHK("wait", v, s)
      give_verdict();
    end
  endtask : wait_for

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) s_axi_bready <= 1'b1;
    end while (!(s_axi_bvalid && s_axi_bready) && n < 50);
    s_axi_bready <= 1'b0;
    resp = s_axi_bresp;
    if (n >= 50) begin
      num_errors++;
      give_verdict();
    end
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) s_axi_rready <= 1'b1;
    end while (!(s_axi_rvalid && s_axi_rready) && n < 50);
    s_axi_rready <= 1'b0;
    rd   = s_axi_rdata;
    resp = s_axi_rresp;
    if (n >= 50) begin
      num_errors++;
      give_verdict();
    end
  endtask : axi_rd

  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    for (k = 0; k < 6; k++) begin
      axi_rd(reg_addr[k]);
      `CHK("reset value", reg_rst[k], rd)
    end
    axi_rd(8'h3C);
    `CHK("unmapped resp", 2'b10, resp)
    axi_wr(bfs_pkg::ADDR_CTRL, 32'h0001_0100);
    axi_wr(bfs_pkg::ADDR_IRQ_MASK, 32'h0000_000F);
    load <= 16'h0100;
    repeat (30) @(posedge clk);
    `CHK("pickup at threshold", 1'b0, start_out)
    load <= 16'h0101;
    wait_for(start_out, 1'b1);
    load <= 16'h00F9;
    repeat (30) @(posedge clk);
    `CHK("held above release", 1'b1, start_out)
    load <= 16'h00F8;
    wait_for(start_out, 1'b0);
    axi_wr(bfs_pkg::ADDR_RETRIP_T, 32'(RT));
    axi_wr(bfs_pkg::ADDR_FAIL_T, 32'(FT));
    // Healthy breaker, stuck breaker with retrip, stuck breaker without
    for (k = 0; k < 3; k++) begin
      axi_wr(bfs_pkg::ADDR_CTRL, k == 2 ? 32'h0000_0100 : 32'h0001_0100);
      stuck <= (k != 0);
      load  <= 16'h0200;
      wait_for(start_out, 1'b1);
      trip_cmd <= 1'b1;
      repeat (80) @(posedge clk);
      `CHK("failure", k != 0, failure_out)
      `CHK("retrip seen", k == 1, t_rt > t_st)
      if (k != 0) `CHK("failure delay", exp_ticks(FT), t_fl - t_st)
      if (k == 1) begin
        `CHK("retrip delay", exp_ticks(RT), t_rt - t_st)
        `CHK("irq", 1'b1, irq)
        axi_rd(bfs_pkg::ADDR_IRQ_STAT);
        `CHK("irq status", 3'h7, rd[2:0])
        axi_wr(bfs_pkg::ADDR_IRQ_MASK, 32'h0);
        `CHK("irq masked", 1'b0, irq)
        axi_wr(bfs_pkg::ADDR_IRQ_MASK, 32'h0000_000F);
      end
      load     <= 16'h0000;
      trip_cmd <= 1'b0;
      wait_for(failure_out, 1'b0);
      wait_for(start_out, 1'b0);
    end
    block_in <= 1'b1;
    load     <= 16'h0200;
    wait_for(blocked_out, 1'b1);
    repeat (60) @(posedge clk);
    `CHK("blocked start", 1'b0, start_out)
    `CHK("blocked failure", 1'b0, failure_out)
    load <= 16'h0000;
    block_in <= 1'b0;
    wait_for(blocked_out, 1'b0);
    axi_wr(bfs_pkg::ADDR_IRQ_STAT, 32'h0000_000F);
    axi_rd(bfs_pkg::ADDR_IRQ_STAT);
    `CHK("irq cleared", 5'h00, {irq, rd[3:0]})
    // Signals then relay commands, first with the wrong activation
    for (k = 0; k < 2; k++) begin
      axi_wr(k ? bfs_pkg::ADDR_DO_MASK : bfs_pkg::ADDR_SIG_MASK, 32'h0000_00FF);
      axi_wr(bfs_pkg::ADDR_CTRL, k ? 32'h0001_0200 : 32'h0001_0400);
      ev = 8'($random(seed)) | 8'h01;
      if (k) relay_commands <= ev;
      else trip_events <= ev;
      repeat (40) @(posedge clk);
      `CHK("gated start", 1'b0, start_out)
      axi_wr(bfs_pkg::ADDR_CTRL, k ? 32'h0001_0400 : 32'h0001_0200);
      wait_for(start_out, 1'b1);
      trip_events    <= 8'h00;
      relay_commands <= 8'h00;
      wait_for(start_out, 1'b0);
    end
    axi_rd(bfs_pkg::ADDR_CTRL);
    `CHK("settings kept", 32'h0001_0400, rd)
    give_verdict();
  end
endmodule : test_breaker_failure_supervisor
`default_nettype wire

//--- rtl/bfs_hyst.sv
`timescale 1ns/1ns
`default_nettype none
module bfs_hyst #(
  parameter int W = 16
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         tick,
  input  wire logic [W-1:0] level,
  input  wire logic [W-1:0] thr,
  output logic              picked
);
  // Release at 97 % of threshold: level*100 < thr*97
  logic [W+7:0] lhs;
  logic [W+7:0] rhs;

  always_comb begin
    lhs = (W+8)'(level) * (W+8)'(100);
    rhs = (W+8)'(thr) * (W+8)'(bfs_pkg::RELEASE_PCT);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      picked <= 1'b0;
    end else if (tick) begin
      if (level > thr) begin
        picked <= 1'b1;
      end else if (lhs < rhs) begin
        picked <= 1'b0;
      end
    end
  end
endmodule : bfs_hyst
`default_nettype wire

//--- rtl/bfs_pkg.sv
package bfs_pkg;

  // ********
  // Register map (byte addresses)
  // ********
  localparam logic [7:0] ADDR_CTRL      = 8'h00;
  localparam logic [7:0] ADDR_PHASE_THR = 8'h04;
  localparam logic [7:0] ADDR_RES_THR   = 8'h08;
  localparam logic [7:0] ADDR_SIG_MASK  = 8'h0C;
  localparam logic [7:0] ADDR_DO_MASK   = 8'h10;
  localparam logic [7:0] ADDR_RETRIP_T  = 8'h14;
  localparam logic [7:0] ADDR_FAIL_T    = 8'h18;
  localparam logic [7:0] ADDR_STATUS    = 8'h1C;
  localparam logic [7:0] ADDR_IRQ_STAT  = 8'h20;
  localparam logic [7:0] ADDR_IRQ_MASK  = 8'h24;
  localparam logic [7:0] ADDR_GLOBAL    = 8'h28;

  // ********
  // Control register fields
  // ********
  localparam int CTRL_MODE_LSB    = 0;   // 3 bits operating mode
  localparam int CTRL_RES_LSB     = 4;   // 2 bits residual source
  localparam int CTRL_ACT_LSB     = 8;   // 4 bits activation mode
  localparam int CTRL_FORCE_LSB   = 12;  // 3 bits forced status
  localparam int CTRL_RETRIP_BIT  = 16;
  localparam int GLOBAL_MODE_BIT  = 0;
  localparam int GLOBAL_FORCE_BIT = 1;

  localparam logic [31:0] CTRL_RESET      = 32'h0001_0000;
  localparam logic [31:0] PHASE_THR_RESET = 32'h0000_0100;
  localparam logic [31:0] RES_THR_RESET   = 32'h0000_0078;
  localparam logic [31:0] RETRIP_T_RESET  = 32'h0000_000A;
  localparam logic [31:0] FAIL_T_RESET    = 32'h0000_0014;

  // ********
  // Timing
  // ********
  localparam int CLK_MHZ       = 50;
  localparam int TICK_MS       = 5;
  localparam int TICK_CYCLES   = TICK_MS * 1000 * CLK_MHZ;
  localparam int RELEASE_PCT   = 97;

  // ********
  // Enumerations
  // ********
  typedef enum logic [2:0] {
    MODE_ON = 3'h0, MODE_BLOCKED = 3'h1, MODE_TEST = 3'h2,
    MODE_TEST_BLOCKED = 3'h3, MODE_OFF = 3'h4
  } op_mode_e;

  typedef enum logic [2:0] {
    ST_NORMAL = 3'h0, ST_START = 3'h1, ST_RETRIP = 3'h2,
    ST_FAILURE = 3'h3, ST_BLOCKED = 3'h4
  } status_e;

  typedef enum logic [1:0] {
    RES_NONE = 2'h0, RES_ONE = 2'h1, RES_TWO = 2'h2, RES_CALC = 2'h3
  } res_src_e;

  // Activation: bit0 current, bit1 signals, bit2 relays, bit3 all-AND
  localparam int ACT_CUR = 0;
  localparam int ACT_SIG = 1;
  localparam int ACT_DO  = 2;
  localparam int ACT_AND = 3;

endpackage : bfs_pkg

//--- rtl/bfs_sync.sv
`timescale 1ns/1ns
`default_nettype none
module bfs_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge clk) begin
    if (rst) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule : bfs_sync
`default_nettype wire

//--- rtl/breaker_failure_supervisor.sv
// Notes on behaviour
// - Retrip, then failure output trips upstream breaker
// - Retrip can be disabled, failure stays
// - Triggers: current, relays, signals, combinations
// - Compare three phases and residual to thresholds
// - Any internal binary signal may start supervision
// - Active monitored relay command starts supervision
// - Magnitudes refreshed on 5 ms base
// - Residual from input one, two or calculated
// - General settings static across setting groups
// - Signal events count only when mode includes signals
// - Relay commands count only when mode includes relays
// - Mode On/Blocked/Test/TestBlocked/Off, gated globally
// - Forced status, only when forcing enabled
// - Pick up above threshold, release below 97 %
// - Blocked at pick-up gives blocked, else start
//
// The AXI4-Lite slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module breaker_failure_supervisor #(
  parameter int W         = 16,
  parameter int NSIG      = 8,
  parameter int NDO       = 8,
  parameter int TICK_CYC  = bfs_pkg::TICK_CYCLES
) (
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic [W-1:0]  phase_one_fundamental,
  input  wire logic [W-1:0]  phase_two_fundamental,
  input  wire logic [W-1:0]  phase_three_fundamental,
  input  wire logic [W-1:0]  residual_input_one,
  input  wire logic [W-1:0]  residual_input_two,
  input  wire logic [W-1:0]  calculated_residual,
  input  wire logic [NSIG-1:0] trip_events,
  input  wire logic [NDO-1:0]  relay_commands,
  input  wire logic          block_in,
  input  wire logic          setting_group_change,
  output logic               start_out,
  output logic               retrip_out,
  output logic               failure_out,
  output logic               blocked_out,
  output logic               irq,
  input  wire logic [7:0]    s_axi_awaddr,
  input  wire logic          s_axi_awvalid,
  output logic               s_axi_awready,
  input  wire logic [31:0]   s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  input  wire logic          s_axi_wvalid,
  output logic               s_axi_wready,
  output logic [1:0]         s_axi_bresp,
  output logic               s_axi_bvalid,
  input  wire logic          s_axi_bready,
  input  wire logic [7:0]    s_axi_araddr,
  input  wire logic          s_axi_arvalid,
  output logic               s_axi_arready,
  output logic [31:0]        s_axi_rdata,
  output logic [1:0]         s_axi_rresp,
  output logic               s_axi_rvalid,
  input  wire logic          s_axi_rready
);

  // ********
  // Input synchronisers
  // ********
  localparam int NIN = 6 * W + NSIG + NDO + 1;
  logic [NIN-1:0] in_sync;
  logic [W-1:0]   ph [3];
  logic [W-1:0]   r1, r2, rc;
  logic [NSIG-1:0] sig_s;
  logic [NDO-1:0]  do_s;
  logic            blk_s;

  // The setting group input is deliberately unused: general settings
  // live in our own registers and ignore group switching.
  bfs_sync #(.W(NIN)) u_sync (
    .clk (clk),
    .rst (rst),
    .d   ({phase_one_fundamental, phase_two_fundamental, phase_three_fundamental,
           residual_input_one, residual_input_two, calculated_residual,
           trip_events, relay_commands, block_in}),
    .q   (in_sync)
  );

  always_comb begin
    {ph[0], ph[1], ph[2], r1, r2, rc, sig_s, do_s, blk_s} = in_sync;
  end

  // ********
  // Registers
  // ********
  logic [31:0] ctrl, phase_thr, res_thr, sig_mask, do_mask;
  logic [31:0] retrip_t, fail_t, irq_mask;
  logic [1:0]  global_en;
  logic [3:0]  irq_stat;
  logic [2:0]  status;

  logic        aw_hold, w_hold;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        do_write;

  always_comb begin
    do_write = aw_hold && w_hold && !s_axi_bvalid;
  end

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  // Address and data may arrive in either order
  always_ff @(posedge clk) begin
    if (rst) begin
      aw_hold <= 1'b0;
      w_hold  <= 1'b0;
      aw_addr <= 8'h00;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (do_write) begin
        aw_hold <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (do_write) begin
        w_hold <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'b00;
    end else begin
      // Ready stays low until the response is gone: one write at a time
      s_axi_awready <= !aw_hold && !(s_axi_awvalid && s_axi_awready) &&
                       !s_axi_bvalid && !do_write;
      s_axi_wready  <= !w_hold && !(s_axi_wvalid && s_axi_wready) &&
                       !s_axi_bvalid && !do_write;
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr > bfs_pkg::ADDR_GLOBAL || aw_addr[1:0] != 2'b00)
                        ? 2'b10 : 2'b00;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl      <= bfs_pkg::CTRL_RESET;
      phase_thr <= bfs_pkg::PHASE_THR_RESET;
      res_thr   <= bfs_pkg::RES_THR_RESET;
      sig_mask  <= 32'h0000_0000;
      do_mask   <= 32'h0000_0000;
      retrip_t  <= bfs_pkg::RETRIP_T_RESET;
      fail_t    <= bfs_pkg::FAIL_T_RESET;
      irq_mask  <= 32'h0000_0000;
      global_en <= 2'b00;
    end else if (do_write) begin
      case (aw_addr)
        bfs_pkg::ADDR_CTRL:      ctrl      <= merge(ctrl, w_data, w_strb);
        bfs_pkg::ADDR_PHASE_THR: phase_thr <= merge(phase_thr, w_data, w_strb);
        bfs_pkg::ADDR_RES_THR:   res_thr   <= merge(res_thr, w_data, w_strb);
        bfs_pkg::ADDR_SIG_MASK:  sig_mask  <= merge(sig_mask, w_data, w_strb);
        bfs_pkg::ADDR_DO_MASK:   do_mask   <= merge(do_mask, w_data, w_strb);
        bfs_pkg::ADDR_RETRIP_T:  retrip_t  <= merge(retrip_t, w_data, w_strb);
        bfs_pkg::ADDR_FAIL_T:    fail_t    <= merge(fail_t, w_data, w_strb);
        bfs_pkg::ADDR_IRQ_MASK:  irq_mask  <= merge(irq_mask, w_data, w_strb);
        bfs_pkg::ADDR_GLOBAL: begin
          if (w_strb[0]) begin
            global_en <= w_data[1:0];
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'b00;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= 2'b00;
        case (s_axi_araddr)
          bfs_pkg::ADDR_CTRL:      s_axi_rdata <= ctrl;
          bfs_pkg::ADDR_PHASE_THR: s_axi_rdata <= phase_thr;
          bfs_pkg::ADDR_RES_THR:   s_axi_rdata <= res_thr;
          bfs_pkg::ADDR_SIG_MASK:  s_axi_rdata <= sig_mask;
          bfs_pkg::ADDR_DO_MASK:   s_axi_rdata <= do_mask;
          bfs_pkg::ADDR_RETRIP_T:  s_axi_rdata <= retrip_t;
          bfs_pkg::ADDR_FAIL_T:    s_axi_rdata <= fail_t;
          bfs_pkg::ADDR_STATUS:    s_axi_rdata <= {29'h0, status};
          bfs_pkg::ADDR_IRQ_STAT:  s_axi_rdata <= {28'h0, irq_stat};
          bfs_pkg::ADDR_IRQ_MASK:  s_axi_rdata <= irq_mask;
          bfs_pkg::ADDR_GLOBAL:    s_axi_rdata <= {30'h0, global_en};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'b10;
          end
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ********
  // Update tick
  // ********
  logic [31:0] tick_cnt;
  logic        tick;

  always_ff @(posedge clk) begin
    if (rst) begin
      tick_cnt <= 32'h0000_0000;
      tick     <= 1'b0;
    end else if (tick_cnt == 32'(TICK_CYC - 1)) begin
      tick_cnt <= 32'h0000_0000;
      tick     <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 32'h0000_0001;
      tick     <= 1'b0;
    end
  end

  // ********
  // Pick-up elements
  // ********
  logic [3:0]   pick;
  logic [W-1:0] res_sel;

  always_comb begin
    case (bfs_pkg::res_src_e'(ctrl[bfs_pkg::CTRL_RES_LSB +: 2]))
      bfs_pkg::RES_ONE:  res_sel = r1;
      bfs_pkg::RES_TWO:  res_sel = r2;
      bfs_pkg::RES_CALC: res_sel = rc;
      default:           res_sel = '0;
    endcase
  end

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_pick
      bfs_hyst #(.W(W)) u_hyst (
        .clk    (clk),
        .rst    (rst),
        .tick   (tick),
        .level  (g < 3 ? ph[g % 3] : res_sel),
        .thr    (g < 3 ? phase_thr[W-1:0] : res_thr[W-1:0]),
        .picked (pick[g])
      );
    end
  endgenerate

  // ********
  // Trigger combination
  // ********
  logic [3:0] act;
  logic       cur_t, sig_t, do_t, trig, res_used;

  always_comb begin
    act      = ctrl[bfs_pkg::CTRL_ACT_LSB +: 4];
    res_used = ctrl[bfs_pkg::CTRL_RES_LSB +: 2] != 2'b00;
    cur_t    = (|pick[2:0]) || (res_used && pick[3]);
    sig_t    = act[bfs_pkg::ACT_SIG] && |(sig_s & sig_mask[NSIG-1:0]);
    do_t     = act[bfs_pkg::ACT_DO] && |(do_s & do_mask[NDO-1:0]);
    if (act[bfs_pkg::ACT_AND]) begin
      trig = (!act[bfs_pkg::ACT_CUR] || cur_t) &&
             (!act[bfs_pkg::ACT_SIG] || sig_t) &&
             (!act[bfs_pkg::ACT_DO] || do_t) && (act[2:0] != 3'b000);
    end else begin
      trig = (act[bfs_pkg::ACT_CUR] && cur_t) || sig_t || do_t;
    end
  end

  // ********
  // Supervision sequence
  // ********
  bfs_pkg::status_e state;
  logic [31:0]      timer;
  logic [2:0]       mode;
  logic             eff_block, retrip_en;
  logic [2:0]       force_sel;

  always_comb begin
    mode      = global_en[bfs_pkg::GLOBAL_MODE_BIT]
                ? ctrl[bfs_pkg::CTRL_MODE_LSB +: 3] : 3'(bfs_pkg::MODE_ON);
    eff_block = blk_s || mode == 3'(bfs_pkg::MODE_BLOCKED) ||
                mode == 3'(bfs_pkg::MODE_TEST_BLOCKED);
    retrip_en = ctrl[bfs_pkg::CTRL_RETRIP_BIT];
    force_sel = ctrl[bfs_pkg::CTRL_FORCE_LSB +: 3];
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state <= bfs_pkg::ST_NORMAL;
      timer <= 32'h0000_0000;
    end else if (tick) begin
      if (mode == 3'(bfs_pkg::MODE_OFF) || !trig) begin
        state <= bfs_pkg::ST_NORMAL;
        timer <= 32'h0000_0000;
      end else begin
        timer <= timer + 32'h0000_0001;
        case (state)
          bfs_pkg::ST_NORMAL: begin
            timer <= 32'h0000_0000;
            state <= eff_block ? bfs_pkg::ST_BLOCKED : bfs_pkg::ST_START;
          end
          bfs_pkg::ST_START: begin
            if (eff_block) begin
              state <= bfs_pkg::ST_BLOCKED;
            end else if (timer + 32'h1 >= fail_t) begin
              state <= bfs_pkg::ST_FAILURE;
            end else if (retrip_en && timer + 32'h1 >= retrip_t) begin
              state <= bfs_pkg::ST_RETRIP;
            end
          end
          bfs_pkg::ST_RETRIP: begin
            if (eff_block) begin
              state <= bfs_pkg::ST_BLOCKED;
            end else if (timer + 32'h1 >= fail_t) begin
              state <= bfs_pkg::ST_FAILURE;
            end
          end
          bfs_pkg::ST_FAILURE: begin
            state <= eff_block ? bfs_pkg::ST_BLOCKED : bfs_pkg::ST_FAILURE;
          end
          default: begin
            timer <= 32'h0000_0000;
          end
        endcase
      end
    end
  end

  // Test modes show the status but hold the trip outputs off
  logic   test_mode;
  logic [2:0] next_status;

  always_comb begin
    test_mode = mode == 3'(bfs_pkg::MODE_TEST) ||
                mode == 3'(bfs_pkg::MODE_TEST_BLOCKED);
    if (global_en[bfs_pkg::GLOBAL_FORCE_BIT] && force_sel != 3'(bfs_pkg::ST_NORMAL)) begin
      next_status = force_sel;
    end else begin
      next_status = 3'(state);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      status      <= 3'(bfs_pkg::ST_NORMAL);
      start_out   <= 1'b0;
      retrip_out  <= 1'b0;
      failure_out <= 1'b0;
      blocked_out <= 1'b0;
    end else begin
      status      <= next_status;
      start_out   <= next_status != 3'(bfs_pkg::ST_NORMAL) &&
                     next_status != 3'(bfs_pkg::ST_BLOCKED);
      retrip_out  <= next_status == 3'(bfs_pkg::ST_RETRIP) && !test_mode && retrip_en;
      failure_out <= next_status == 3'(bfs_pkg::ST_FAILURE) && !test_mode;
      blocked_out <= next_status == 3'(bfs_pkg::ST_BLOCKED);
    end
  end

  // ********
  // Interrupts: start, retrip, failure, blocked rising edges
  // ********
  logic [3:0] ev, ev_prev;

  always_comb begin
    ev = {blocked_out, failure_out, retrip_out, start_out};
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ev_prev  <= 4'h0;
      irq_stat <= 4'h0;
      irq      <= 1'b0;
    end else begin
      ev_prev <= ev;
      // Set wins over a simultaneous write-one clear
      irq_stat <= (irq_stat & ~((do_write && aw_addr == bfs_pkg::ADDR_IRQ_STAT && w_strb[0])
                                ? w_data[3:0] : 4'h0)) | (ev & ~ev_prev);
      irq <= |(irq_stat & irq_mask[3:0]);
    end
  end

endmodule : breaker_failure_supervisor
`default_nettype wire
